/* logic/gpd_params.svh */
/*
 * Constants of the general pin data and link diagnostic register block:
 * configuration offsets, reset values, write masks and pin sharing masks.
 * Assumes it is included by bare name and that every user is SystemVerilog.
 */
`ifndef GPD_PARAMS_SVH
`define GPD_PARAMS_SVH

// Configuration offsets, bytes
`define GPD_OFS_PIN_DIR 8'hb4
`define GPD_OFS_PIN_DATA 8'hb6
`define GPD_OFS_DIAG0 8'hc0
`define GPD_OFS_DIAG1 8'hc4

// Byte lane of the dword at b4h that carries the pin data low byte
`define GPD_PIN_DATA_LANE 2
// Bit of the dword at b4h where pin data bit 0 sits
`define GPD_PIN_DATA_POS 16

// Reset values
`define GPD_DIR_RESET 5'h00
`define GPD_PIN_LATCH_RESET 5'h00
`define GPD_DIAG0_RESET 32'h00000001
`define GPD_DIAG1_RESET 32'h00120108

// Software-writable bits: 18, 15:14, 11:7, 2, 1, 0
`define GPD_DIAG0_WMASK 32'h0004cf87
// Bits 31:21 of the second diagnostic register are reserved
`define GPD_DIAG1_WMASK 32'h001fffff

// Pins able to carry a secondary function: 0, 1, 3, 4 (pin 2 cannot)
`define GPD_SEC_CAPABLE 5'h1b

`endif

/* logic/gpd_pkg.sv */
/*
 * Types of the pin data and link diagnostic register block: the states of
 * the access responder, the configuration request carrier, the layout of
 * the first diagnostic register and the secondary function bundle.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpd_pkg;

	// Access responder states, one-hot
	typedef enum logic [1:0] {
		GPD_ST_IDLE = 2'b01,
		GPD_ST_RESP = 2'b10
	} gpd_state_t;

	// One configuration access as the link core hands it over
	typedef struct packed {
		logic we;           // 1 write, 0 read
		logic [7:0] addr;   // Byte offset, dword aligned use of [7:2]
		logic [3:0] be;     // Byte enables
		logic [31:0] wdata; // Write data
	} gpd_cfg_req_t;

	// First diagnostic register, bit 31 first
	typedef struct packed {
		logic [7:0] captured_bus_number;    // 31:24
		logic [4:0] captured_device_number; // 23:19
		logic advisory_report_disable;      // 18
		logic [1:0] rsv_ro_17;              // 17:16
		logic [1:0] rsv_rw_15;              // 15:14
		logic [1:0] rsv_ro_13;              // 13:12
		logic [4:0] rsv_rw_11;              // 11:7
		logic [3:0] rsv_ro_6;               // 6:3
		logic mmio_cfg_access;              // 2
		logic rsv_rw_1;                     // 1
		logic hold_clock_request_asserted;  // 0
	} gpd_diag0_t;

	// Secondary functions sharing the pins
	typedef struct packed {
		logic [4:0] enable; // Pin taken by its secondary function
		logic [4:0] level;  // Level the function drives
		logic [4:0] drive;  // Function drives the pin, active high
	} gpd_sec_t;

endpackage

/* logic/gpd_pin_port.sv */
/*
 * Output latches and pin drivers of the five general pins.
 * Assumes pin inputs synchronous to ref_clk and a synchronous reset that
 * already merges every reset source.
 */
`timescale 1ns/1ps
`include "gpd_params.svh"

module gpd_pin_port (
	input wire logic ref_clk,           // 125 MHz clock
	input wire logic any_reset,         // Merged synchronous reset
	input wire logic ce,                // Clock enable, freezes state when low
	input wire logic data_wr,           // Write to the pin data byte
	input wire logic [4:0] data_wdata,  // Written pin data
	input wire logic [4:0] dir,         // 1 = output mode
	input wire logic [4:0] sec_enable,  // Pin taken by secondary function
	input wire logic [4:0] sec_level,   // Secondary drive level
	input wire logic [4:0] sec_drive,   // Secondary drives the pin
	output logic [4:0] out_level,       // Output latches
	output logic [4:0] pin_out,         // Pin output value
	output logic [4:0] pin_oe_n         // Pin output enable, low drives
);

	logic [4:0] next_latch;  // Next output latches
	logic [4:0] next_out;    // Next pin value
	logic [4:0] next_oe_n;   // Next pin enable
	logic [4:0] take_mask;   // Bits that accept a write

	// Only general output pins take a written value; others keep theirs
	always_comb begin
		take_mask = dir & ~sec_enable;
		next_latch = out_level;
		if (data_wr) begin
			next_latch = (out_level & ~take_mask) | (data_wdata & take_mask);
		end
		// Secondary function owns the pad, else direction decides
		next_out = (sec_enable & sec_level) | (~sec_enable & out_level);
		next_oe_n = ~((sec_enable & sec_drive) | (~sec_enable & dir));
	end

	// Pads released at reset, so every pin starts as an input
	always_ff @(posedge ref_clk) begin
		if (any_reset) begin
			out_level <= `GPD_PIN_LATCH_RESET;
			pin_out <= 5'h00;
			pin_oe_n <= 5'h1f;
		end else if (ce) begin
			out_level <= next_latch;
			pin_out <= next_out;
			pin_oe_n <= next_oe_n;
		end
	end

endmodule

/* logic/gpd_regs.sv */
/*
 * Pin data, pin direction and link diagnostic registers of the bridge
 * configuration space, with capture of the bus and device number.
 * Assumes one configuration access per request pulse from the link core,
 * pin inputs synchronous to ref_clk, and reset inputs synchronous too.
 */
`timescale 1ns/1ps
`include "gpd_params.svh"

module gpd_regs (
	input wire logic ref_clk,                      // 125 MHz clock
	input wire logic rst,                          // Power-on reset, active high
	input wire logic ce,                           // Clock enable
	input wire logic link_reset_in,                // Link fundamental reset
	input wire logic global_reset_in,              // Global reset input
	input wire logic cfg_req,                      // Access request pulse
	input wire gpd_pkg::gpd_cfg_req_t cfg_cmd,     // Access carrier
	output logic cfg_ack,                          // Access answer
	output logic [31:0] cfg_rdata,                 // Read data
	input wire logic tlp_cfg0_wr,                  // Type 0 config write seen
	input wire logic [7:0] tlp_bus_number,         // Its target bus
	input wire logic [4:0] tlp_device_number,      // Its target device
	input wire logic [4:0] pin_in,                 // Pin levels
	output logic [4:0] pin_out,                    // Pin drive values
	output logic [4:0] pin_oe_n,                   // Pin enables, low drives
	input wire gpd_pkg::gpd_sec_t sec,             // Secondary functions
	input wire logic clock_request_in,             // Power logic wants clock
	output logic clock_request_n,                  // Clock request pin
	output logic mmio_cfg_access_en,               // Config to mmio allowed
	output logic advisory_report_disable,          // Error method select
	output logic [31:0] diag1_value                // Second diagnostic register
);

	// Dword index of a byte offset
	function automatic logic [5:0] dword_of(input logic [7:0] a);
		return a[7:2];
	endfunction

	// Byte-lane merge limited to writable bits
	function automatic logic [31:0] merge_be(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		return (old & ~m) | (val & m);
	endfunction

	logic any_reset;                  // Any of the three resets
	gpd_pkg::gpd_state_t state;       // Responder state
	gpd_pkg::gpd_state_t next_state;  // Next responder state
	logic [4:0] dir;                  // Pin direction bits
	logic [4:0] next_dir;             // Next direction bits
	gpd_pkg::gpd_diag0_t diag0;       // First diagnostic register
	gpd_pkg::gpd_diag0_t next_diag0;  // Its next value
	logic [31:0] diag1;               // Second diagnostic register
	logic [31:0] next_diag1;          // Its next value
	logic [31:0] next_rdata;          // Next read data
	logic next_clkreq_n;              // Next clock request pin
	logic take;                       // Access accepted this edge
	logic hit_pin;                    // Dword b4h addressed
	logic hit_d0;                     // Dword c0h addressed
	logic hit_d1;                     // Dword c4h addressed
	logic [4:0] sec_eff;              // Secondary enables on capable pins
	logic [4:0] drive_mask;           // General output pins
	logic [4:0] out_level;            // Output latches
	logic [4:0] rd_level;             // Pin data as read
	logic data_wr;                    // Write hits pin data byte

	// Three reset sources act alike on every stored field
	assign any_reset = rst | link_reset_in | global_reset_in;

	// Pin 2 has no secondary function, so its enable is dropped here
	assign sec_eff = sec.enable & `GPD_SEC_CAPABLE;
	assign drive_mask = dir & ~sec_eff;

	// Inputs and shared pins read the pad; outputs read their latch
	assign rd_level = (drive_mask & out_level) | (~drive_mask & pin_in);

	// Decode is on dwords; b6h shares the dword at b4h
	assign hit_pin = dword_of(cfg_cmd.addr) == dword_of(`GPD_OFS_PIN_DIR);
	assign hit_d0 = dword_of(cfg_cmd.addr) == dword_of(`GPD_OFS_DIAG0);
	assign hit_d1 = dword_of(cfg_cmd.addr) == dword_of(`GPD_OFS_DIAG1);

	// A request is taken only while idle and enabled
	assign take = ce && cfg_req && (state == gpd_pkg::GPD_ST_IDLE);
	assign data_wr = take && cfg_cmd.we && hit_pin && cfg_cmd.be[`GPD_PIN_DATA_LANE];

	// Answer is a handshake output, so it may follow the state directly
	assign cfg_ack = ce && (state == gpd_pkg::GPD_ST_RESP);

	// Control fields go straight out of their flip-flops
	assign mmio_cfg_access_en = diag0.mmio_cfg_access;
	assign advisory_report_disable = diag0.advisory_report_disable;
	assign diag1_value = diag1;

	gpd_pin_port u_pins (
		.ref_clk(ref_clk),
		.any_reset(any_reset),
		.ce(ce),
		.data_wr(data_wr),
		.data_wdata(cfg_cmd.wdata[`GPD_PIN_DATA_POS +: 5]),
		.dir(dir),
		.sec_enable(sec_eff),
		.sec_level(sec.level),
		.sec_drive(sec.drive),
		.out_level(out_level),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n)
	);

	// Responder: one answer cycle after each accepted request
	always_comb begin
		next_state = state;
		case (state)
			gpd_pkg::GPD_ST_IDLE: begin
				if (take) begin
					next_state = gpd_pkg::GPD_ST_RESP;
				end
			end
			gpd_pkg::GPD_ST_RESP: begin
				next_state = gpd_pkg::GPD_ST_IDLE;
			end
			default: begin
				next_state = gpd_pkg::GPD_ST_IDLE;
			end
		endcase
	end

	// Register contents and read data
	always_comb begin
		next_dir = dir;
		next_diag0 = diag0;
		next_diag1 = diag1;
		next_rdata = cfg_rdata;
		if (take && cfg_cmd.we) begin
			// Direction sits in the low byte of the pin dword
			if (hit_pin && cfg_cmd.be[0]) begin
				next_dir = cfg_cmd.wdata[4:0];
			end
			// Reserved read-only bits and captured numbers are not in the mask
			if (hit_d0) begin
				next_diag0 = merge_be(diag0, cfg_cmd.wdata, cfg_cmd.be,
					`GPD_DIAG0_WMASK);
			end
			// Writable reserved bits are kept as written; zero is expected
			if (hit_d1) begin
				next_diag1 = merge_be(diag1, cfg_cmd.wdata, cfg_cmd.be,
					`GPD_DIAG1_WMASK);
			end
		end
		// Capture follows software, so a same-edge write cannot undo it
		if (tlp_cfg0_wr) begin
			next_diag0.captured_bus_number = tlp_bus_number;
			next_diag0.captured_device_number = tlp_device_number;
		end
		if (take && !cfg_cmd.we) begin
			// Unmapped dwords read as zero
			next_rdata = 32'h00000000;
			if (hit_pin) begin
				next_rdata = {11'h000, rd_level, 11'h000, dir};
			end else if (hit_d0) begin
				next_rdata = diag0;
			end else if (hit_d1) begin
				next_rdata = diag1;
			end
		end
		// Forced request wins over the power logic's own wish
		next_clkreq_n = ~(diag0.hold_clock_request_asserted | clock_request_in);
	end

	// Reset ahead of the enable so a frozen block still resets
	always_ff @(posedge ref_clk) begin
		if (any_reset) begin
			state <= gpd_pkg::GPD_ST_IDLE;
			dir <= `GPD_DIR_RESET;
			diag0 <= `GPD_DIAG0_RESET;
			diag1 <= `GPD_DIAG1_RESET;
			cfg_rdata <= 32'h00000000;
			clock_request_n <= 1'b1;
		end else if (ce) begin
			state <= next_state;
			dir <= next_dir;
			diag0 <= next_diag0;
			diag1 <= next_diag1;
			cfg_rdata <= next_rdata;
			clock_request_n <= next_clkreq_n;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (any_reset);

	// Read of an input pin returns the level seen at the take edge
	input_read_a: assert property (
		(take && !cfg_cmd.we && hit_pin) |=>
		((cfg_rdata[20:16] & ~$past(drive_mask)) == ($past(pin_in) & ~$past(drive_mask))))
		else $error("input pin read mismatch");

	// Writes leave input and shared pins untouched
	write_ignore_a: assert property (
		data_wr |=> (((out_level ^ $past(out_level)) & ~$past(drive_mask)) == 5'h00))
		else $error("ignored pin bit changed");

	// Output pins take the written value on the matching bit
	write_take_a: assert property (
		data_wr |=> ((out_level & $past(drive_mask)) ==
		($past(cfg_cmd.wdata[20:16]) & $past(drive_mask))))
		else $error("output pin bit not written");

	// Pin 2 follows its direction bit even when sharing is requested
	pin_two_a: assert property (
		(ce && sec.enable[2]) |=> (pin_oe_n[2] == !$past(dir[2])))
		else $error("pin 2 taken by secondary");

	// Reserved pin bits read zero
	pin_rsvd_a: assert property (
		(take && !cfg_cmd.we && hit_pin) |=> ((cfg_rdata[31:21] == 11'h000) &&
		(cfg_rdata[15:5] == 11'h000)))
		else $error("pin reserved bits not zero");

	// Defaults after any reset
	reset_value_a: assert property (
		$past(any_reset) |-> ((diag0 == `GPD_DIAG0_RESET) && (dir == 5'h00) &&
		(diag1 == `GPD_DIAG1_RESET) && (pin_oe_n == 5'h1f)))
		else $error("reset value wrong");

	// Captured numbers follow a type 0 write
	capture_a: assert property (
		(ce && tlp_cfg0_wr) |=> ((diag0.captured_bus_number == $past(tlp_bus_number)) &&
		(diag0.captured_device_number == $past(tlp_device_number))))
		else $error("bus or device not captured");

	// Software cannot alter the captured bus number
	bus_readonly_a: assert property (
		(take && cfg_cmd.we && hit_d0 && !tlp_cfg0_wr) |=>
		$stable(diag0.captured_bus_number))
		else $error("captured bus overwritten");

	// Read-only reserved fields stay zero after writes
	diag_rsvd_a: assert property (
		(take && cfg_cmd.we && hit_d0) |=> ((diag0.rsv_ro_17 == 2'h0) &&
		(diag0.rsv_ro_13 == 2'h0) && (diag0.rsv_ro_6 == 4'h0)))
		else $error("diag reserved bit set");

	// Error method and mmio access follow the written bits
	control_bits_a: assert property (
		(take && cfg_cmd.we && hit_d0 && (cfg_cmd.be[2:0] == 3'h7)) |=>
		((advisory_report_disable == $past(cfg_cmd.wdata[18])) &&
		(mmio_cfg_access_en == $past(cfg_cmd.wdata[2]))))
		else $error("control bit not written");

	// Held request keeps the pin low
	clock_hold_a: assert property (
		(ce && diag0.hold_clock_request_asserted) |=> !clock_request_n)
		else $error("clock request not held");

	// Direction write reaches the pad enables two edges on
	direction_a: assert property (
		(take && cfg_cmd.we && hit_pin && cfg_cmd.be[0] && sec_eff == 5'h00) ##1 ce |=>
		(pin_oe_n == ~$past(cfg_cmd.wdata[4:0], 2)))
		else $error("direction not applied");

	// Read-only reserved fields also read zero on the bus, not only in storage
	diag_rsvd_read_a: assert property (
		(take && !cfg_cmd.we && hit_d0) |=> ((cfg_rdata[17:16] == 2'h0) &&
		(cfg_rdata[13:12] == 2'h0) && (cfg_rdata[6:3] == 4'h0)))
		else $error("diag reserved bits read nonzero");

	// A read returns the numbers captured before the take edge
	capture_read_a: assert property (
		(take && !cfg_cmd.we && hit_d0) |=> (cfg_rdata[31:19] ==
		$past({diag0.captured_bus_number, diag0.captured_device_number})))
		else $error("captured numbers not read back");

	// Power logic alone may still ask for the clock when the hold bit is clear
	clock_want_a: assert property (
		(ce && clock_request_in) |=> !clock_request_n)
		else $error("clock request from power logic lost");

	pin_read_c: cover property (take && !cfg_cmd.we && hit_pin);
	diag1_write_c: cover property (take && cfg_cmd.we && hit_d1);
	diag_write_c: cover property (take && cfg_cmd.we && hit_d0);
	capture_c: cover property (tlp_cfg0_wr && take && hit_d0);
	release_c: cover property (diag0.hold_clock_request_asserted ##1
		!diag0.hold_clock_request_asserted);

endmodule

/* tb/testbench.sv */
/*
 * Self-checking bench for the pin data and link diagnostic register block.
 * Assumes the logic/ files compile first and that gpd_params.svh is reachable
 * by bare name on the include path.
 */
`timescale 1ns/1ps
`include "gpd_params.svh"

module testbench;

	// One pin scenario: inputs beside the outputs they should give
	typedef struct {
		logic [4:0] dir; // Direction written
		logic [4:0] sec; // Secondary enables asked for
		logic [4:0] lvl; // Secondary levels
		logic [4:0] drv; // Secondary drives
		logic [4:0] pin; // Pad levels
		logic [4:0] wr;  // Pin data written
		logic [4:0] rd;  // Pin data read back, secondary-owned outputs masked
		logic [4:0] oe;  // Expected pad enables, low drives
		logic [4:0] out; // Expected pad values where driven
	} gpd_tb_row_t;

	logic ref_clk = 1'b0; // Bench clock
	logic rst = 1'b1; // Power-on reset
	logic ce = 1'b1; // Clock enable
	logic link_reset_in = 1'b0; // Link reset
	logic global_reset_in = 1'b0; // Global reset
	logic cfg_req = 1'b0; // Access pulse
	gpd_pkg::gpd_cfg_req_t cfg_cmd = '0; // Access carrier
	logic cfg_ack; // Access answer
	logic [31:0] cfg_rdata; // Read data
	logic tlp_cfg0_wr = 1'b0; // Capture pulse
	logic [7:0] tlp_bus_number = 8'h00; // Captured bus source
	logic [4:0] tlp_device_number = 5'h00; // Captured device source
	logic [4:0] pin_in = 5'h0a; // Pad levels
	logic [4:0] pin_out; // Pad values
	logic [4:0] pin_oe_n; // Pad enables
	gpd_pkg::gpd_sec_t sec = '0; // Secondary functions
	logic clock_request_in = 1'b0; // Power logic clock want
	logic clock_request_n; // Clock request pin
	logic mmio_cfg_access_en; // Diag bit 2
	logic advisory_report_disable; // Diag bit 18
	logic [31:0] diag1_value; // Second diagnostic register
	int bad_count = 0; // Mismatches
	int comparisons = 0; // Comparisons made
	logic [31:0] v; // Scratch read value

	// Hand-computed pin cases; rows stand alone so order does not matter
	gpd_tb_row_t rows [5] = '{
		'{5'h00, 5'h00, 5'h00, 5'h00, 5'h15, 5'h1f, 5'h15, 5'h1f, 5'h00},
		'{5'h1f, 5'h00, 5'h00, 5'h00, 5'h00, 5'h0a, 5'h0a, 5'h00, 5'h0a},
		'{5'h1f, 5'h00, 5'h00, 5'h00, 5'h1f, 5'h15, 5'h15, 5'h00, 5'h15},
		'{5'h1f, 5'h1f, 5'h05, 5'h11, 5'h00, 5'h1f, 5'h04, 5'h0a, 5'h05},
		'{5'h0c, 5'h03, 5'h00, 5'h00, 5'h1b, 5'h00, 5'h13, 5'h13, 5'h00}
	};

	gpd_regs gpd_regs_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.link_reset_in(link_reset_in),
		.global_reset_in(global_reset_in),
		.cfg_req(cfg_req),
		.cfg_cmd(cfg_cmd),
		.cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata),
		.tlp_cfg0_wr(tlp_cfg0_wr),
		.tlp_bus_number(tlp_bus_number),
		.tlp_device_number(tlp_device_number),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.sec(sec),
		.clock_request_in(clock_request_in),
		.clock_request_n(clock_request_n),
		.mmio_cfg_access_en(mmio_cfg_access_en),
		.advisory_report_disable(advisory_report_disable),
		.diag1_value(diag1_value)
	);

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	// Step to just after the next rising edge, where inputs may change
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	// Compare and count; four-state so an unknown never matches
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	// One access: pulse, then a bounded wait for the answer cycle
	task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		cfg_req = 1'b1;
		cfg_cmd = {we, a, be, wd};
		tick();
		cfg_req = 1'b0;
		n = 0;
		while (cfg_ack !== 1'b1 && n < 4) begin
			tick();
			n++;
		end
		check(cfg_ack, 1'b1, "access not answered");
		rd = cfg_rdata;
		tick();
	endtask

	task automatic wr32(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] unused;
		cfg(1'b1, a, be, d, unused);
	endtask

	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		cfg(1'b0, a, 4'hf, 32'h0, d);
	endtask

	// One capture pulse with the given numbers
	task automatic capture(input logic [7:0] b, input logic [4:0] d);
		tlp_cfg0_wr = 1'b1;
		tlp_bus_number = b;
		tlp_device_number = d;
		tick();
		tlp_cfg0_wr = 1'b0;
	endtask

	// Single place where the run ends
	task automatic stop_test();
		$display("comparisons %0d, bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog, far beyond the fewer than two hundred cycles the sequence needs
	initial begin
		#200000;
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		tick();
		rd32(8'hc0, v);
		check(v, 32'h00000001, "diag0 reset");
		rd32(8'hc4, v);
		check(v, 32'h00120108, "diag1 reset");
		check(diag1_value, 32'h00120108, "diag1 port reset");
		rd32(8'hb4, v);
		check(v, 32'h000a0000, "pin data after reset");
		check(pin_oe_n, 5'h1f, "pins released after reset");
		check(clock_request_n, 1'b0, "clock request held");
		// Pin cases from the table
		foreach (rows[i]) begin
			sec = {rows[i].sec, rows[i].lvl, rows[i].drv};
			pin_in = rows[i].pin;
			wr32(8'hb4, 4'h1, {27'h0, rows[i].dir});
			wr32(8'hb4, 4'h4, {11'h0, rows[i].wr, 16'h0});
			tick();
			tick();
			rd32(8'hb4, v);
			check(v[20:16] & ~(rows[i].dir & rows[i].sec & `GPD_SEC_CAPABLE), rows[i].rd,
				"pin data read");
			check(v[4:0], rows[i].dir, "direction read");
			check({v[31:21], v[15:5]}, 22'h0, "reserved pin bits");
			check(pin_oe_n, rows[i].oe, "pad enables");
			check(pin_out & ~rows[i].oe, rows[i].out, "pad values");
		end
		sec = '0;
		// Ones aimed at read-only bits must vanish; writable reserved bits get zeros
		wr32(8'hc0, 4'hf, 32'hffff307c);
		rd32(8'hc0, v);
		check(v, 32'h00040004, "diag0 write");
		check(mmio_cfg_access_en, 1'b1, "mmio access bit");
		check(advisory_report_disable, 1'b1, "report method bit");
		tick();
		check(clock_request_n, 1'b1, "clock request released");
		clock_request_in = 1'b1;
		tick();
		tick();
		check(clock_request_n, 1'b0, "clock request from power logic");
		clock_request_in = 1'b0;
		// Lane 0 only: bit 2 kept set, bit 0 set again, bit 18 in lane 2 untouched
		wr32(8'hc0, 4'h1, 32'h00000005);
		rd32(8'hc0, v);
		check(v, 32'h00040005, "diag0 byte lane");
		// Capture, then back-to-back captures where the last wins
		capture(8'ha5, 5'h13);
		rd32(8'hc0, v);
		check(v, 32'ha59c0005, "captured numbers");
		capture(8'h11, 5'h01);
		capture(8'h3c, 5'h1f);
		rd32(8'hc0, v);
		check(v, 32'h3cfc0005, "back to back capture");
		// Clock enable low: a capture pulse must not land
		ce = 1'b0;
		capture(8'h77, 5'h07);
		ce = 1'b1;
		rd32(8'hc0, v);
		check(v, 32'h3cfc0005, "capture frozen by ce");
		// Unmapped dword: write ignored, read zero
		wr32(8'h10, 4'hf, 32'h12345678);
		rd32(8'h10, v);
		check(v, 32'h0, "unmapped read");
		// Second register: top bits are read-only, reserved writable bits get zeros
		wr32(8'hc4, 4'hf, 32'hffff87fc);
		rd32(8'hc4, v);
		check(v, 32'h001f87fc, "diag1 write");
		check(diag1_value, 32'h001f87fc, "diag1 port after write");
		// Software puts the defaults back, as it is advised to
		wr32(8'hc4, 4'hf, `GPD_DIAG1_RESET);
		check(diag1_value, `GPD_DIAG1_RESET, "diag1 defaults restored");
		// Each reset source alone restores the defaults
		for (int k = 0; k < 3; k++) begin
			wr32(8'hc0, 4'hf, 32'h00040004);
			wr32(8'hc4, 4'hf, 32'h00000000);
			wr32(8'hb4, 4'h1, 32'h0000001f);
			capture(8'h5a, 5'h0b);
			rst = (k == 0);
			link_reset_in = (k == 1);
			global_reset_in = (k == 2);
			tick();
			tick();
			rst = 1'b0;
			link_reset_in = 1'b0;
			global_reset_in = 1'b0;
			tick();
			rd32(8'hc0, v);
			check(v, 32'h00000001, "diag0 after reset source");
			check(diag1_value, `GPD_DIAG1_RESET, "diag1 after reset source");
			rd32(8'hb4, v);
			check(v, {11'h0, pin_in, 16'h0}, "pin register after reset source");
			check(pin_oe_n, 5'h1f, "pads released after reset source");
		end
		stop_test();
	end

endmodule
